//--- design/e1_sa_select_loop.sv
// National bit source select and automatic local loopback for the E1 transmit path
//
// Behaviour
// - Select bit 7 picks Sa8 source.
// - Select bit 6 picks Sa7 source.
// - Select bit 5 picks Sa6 source.
// - Select bit 4 picks Sa5 source.
// - Select bit 3 picks Sa4 source.
// - Pattern one, eight octets, enters loopback.
// - Pattern two, eight octets, enters loopback.
// - Sa5, Sa6 zero eight octets releases.
// - Auto loopback needs Sa5, Sa6 from input.
`timescale 1ns/1ps
`include "e1_sa_consts.svh"
module e1_sa_select_loop (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register bus
   input wire e1_sa_pkg::axi_req_s axi_req,
   output e1_sa_pkg::axi_rsp_s axi_rsp,
   // Frame timing from the transmit framer
   input wire logic bit_strobe,
   input wire e1_sa_pkg::frame_pos_s frame_pos,
   // Backplane serial data
   input wire logic tx_serial_input,
   // Line side serial data
   output logic tx_serial_out,
   output logic tx_out_strobe,
   // Loopback and defect control
   output logic local_loop_en,
   output logic defect_detect_on
);
   import e1_sa_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam int NSA = 5;
   localparam int NPAT = 3;

   logic ser_sync;
   logic strobe_p1_q;
   logic strobe_p2_q;
   frame_pos_s pos_p1_q;
   frame_pos_s pos_p2_q;

   logic [7:0] sel_q;
   logic [7:0] defect_q;
   logic [7:0] sa_tx_q [NSA];

   logic aw_held_q;
   logic [11:0] aw_addr_q;
   logic w_held_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic wr_fire;
   logic [9:0] wr_idx;
   logic wr_ok;
   logic rd_fire;
   logic [9:0] rd_idx;
   logic [31:0] rd_data;
   logic rd_ok;

   logic [7:0] sa5_oct_q;
   logic [7:0] sa6_oct_q;
   logic [7:0] a_oct_q;
   logic [23:0] last_oct_q;
   logic nfas_bit;
   logic octet_done;
   logic src_ok;
   logic [NPAT-1:0] pat_match;
   logic [NPAT-1:0] pat_en;
   logic [NPAT-1:0] pat_reached;
   logic [`CNT_W-1:0] pat_cnt [NPAT];

   loop_state_e state_q;
   loop_state_e state_d;

   logic ins_slot;
   logic [2:0] sa_n;
   logic out_bit;
   logic out_bit_q;
   logic out_strobe_q;

   // ----------------------------------------
   // Backplane input and timing alignment
   // ----------------------------------------

   // Serial pin crosses into the framer clock through two stages
   bit_sync2 #(
      .W(1)
   ) u_ser_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(tx_serial_input),
      .sync_out(ser_sync)
   );

   // Timing is delayed by the same two cycles as the data
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strobe_p1_q <= 1'b0;
         strobe_p2_q <= 1'b0;
         pos_p1_q <= '0;
         pos_p2_q <= '0;
      end else begin
         strobe_p1_q <= bit_strobe;
         strobe_p2_q <= strobe_p1_q;
         pos_p1_q <= frame_pos;
         pos_p2_q <= pos_p1_q;
      end
   end

   assign nfas_bit = strobe_p2_q && pos_p2_q.in_ts0 && pos_p2_q.nfas;

   // ----------------------------------------
   // Register bus, write side
   // ----------------------------------------

   // Address and data are taken in either order and held
   always_ff @(posedge clk) begin
      if (!rstn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (axi_req.awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= axi_req.awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (axi_req.wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         w_data_q <= axi_req.wdata;
         w_strb_q <= axi_req.wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_idx = aw_addr_q[11:2];
   assign wr_ok = (aw_addr_q[1:0] == 2'h0) &&
                  ((wr_idx == `IDX_SEL) || (wr_idx == `IDX_DEFECT) ||
                   ((wr_idx >= `IDX_SA4) && (wr_idx <= `IDX_SA8)) ||
                   (wr_idx == `IDX_STATUS) || (wr_idx == `IDX_OCTETS));

   // Write response; unmapped or misaligned writes answer SLVERR
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (axi_req.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Select register steers insertion and the loopback enables
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sel_q <= `SEL_RST;
      end else if (wr_fire && wr_ok && w_strb_q[0] && wr_idx == `IDX_SEL) begin
         sel_q <= w_data_q[7:0];
      end
   end

   // Defect detection enable; reset leaves it set as software should
   always_ff @(posedge clk) begin
      if (!rstn) begin
         defect_q <= `DEFECT_RST;
      end else if (wr_fire && wr_ok && w_strb_q[0] && wr_idx == `IDX_DEFECT) begin
         defect_q <= w_data_q[7:0];
      end
   end

   assign defect_detect_on = defect_q[7];

   // One transmit octet register per national bit Sa4 to Sa8
   for (genvar g = 0; g < NSA; g++) begin : g_sa_reg
      always_ff @(posedge clk) begin
         if (!rstn) begin
            sa_tx_q[g] <= `SA_REG_RST;
         end else if (wr_fire && wr_ok && w_strb_q[0] &&
                      wr_idx == `IDX_SA4 + 10'(g)) begin
            sa_tx_q[g] <= w_data_q[7:0];
         end
      end
   end

   // ----------------------------------------
   // Register bus, read side
   // ----------------------------------------
   assign rd_fire = axi_req.arvalid && !rvalid_q;
   assign rd_idx = axi_req.araddr[11:2];

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_data = '0;
      rd_ok = (axi_req.araddr[1:0] == 2'h0);
      if (rd_idx == `IDX_SEL) begin
         rd_data[7:0] = sel_q;
      end else if (rd_idx == `IDX_DEFECT) begin
         rd_data[7:0] = defect_q;
      end else if (rd_idx >= `IDX_SA4 && rd_idx <= `IDX_SA8) begin
         rd_data[7:0] = sa_tx_q[3'(rd_idx - `IDX_SA4)];
      end else if (rd_idx == `IDX_STATUS) begin
         rd_data[0] = (state_q == LOOP_ON);
         rd_data[7:4] = pat_cnt[0];
         rd_data[11:8] = pat_cnt[1];
         rd_data[15:12] = pat_cnt[2];
      end else if (rd_idx == `IDX_OCTETS) begin
         rd_data[23:0] = last_oct_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Read data is registered and held until rready
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_ok ? rd_data : '0;
         rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign axi_rsp.awready = !aw_held_q;
   assign axi_rsp.wready = !w_held_q;
   assign axi_rsp.bvalid = bvalid_q;
   assign axi_rsp.bresp = bresp_q;
   assign axi_rsp.arready = !rvalid_q;
   assign axi_rsp.rvalid = rvalid_q;
   assign axi_rsp.rdata = rdata_q;
   assign axi_rsp.rresp = rresp_q;

   // ----------------------------------------
   // Pattern monitor on the backplane input
   // ----------------------------------------

   // Shift in A, Sa5 and Sa6 of each NFAS frame, oldest bit first
   always_ff @(posedge clk) begin
      if (!rstn) begin
         a_oct_q <= '0;
         sa5_oct_q <= '0;
         sa6_oct_q <= '0;
      end else if (nfas_bit) begin
         if (pos_p2_q.ts0_bit == `POS_A) begin
            a_oct_q <= {a_oct_q[6:0], ser_sync};
         end
         if (pos_p2_q.ts0_bit == `POS_SA5) begin
            sa5_oct_q <= {sa5_oct_q[6:0], ser_sync};
         end
         if (pos_p2_q.ts0_bit == `POS_SA6) begin
            sa6_oct_q <= {sa6_oct_q[6:0], ser_sync};
         end
      end
   end

   // An octet closes at the last national bit of the eighth NFAS frame
   assign octet_done = nfas_bit && pos_p2_q.ts0_bit == `POS_SA8 &&
                       pos_p2_q.nfas_index == `OCTET_LAST;

   // Keep the last full octets for software to inspect
   always_ff @(posedge clk) begin
      if (!rstn) begin
         last_oct_q <= '0;
      end else if (octet_done) begin
         last_oct_q <= {a_oct_q, sa6_oct_q, sa5_oct_q};
      end
   end

   // Patterns only mean something when Sa5 and Sa6 come from the pin
   assign src_ok = !sel_q[`BIT_SEL_SA5] && !sel_q[`BIT_SEL_SA6];

   assign pat_match[0] = sa5_oct_q == `PAT_ZERO && sa6_oct_q == `PAT_ONES &&
                         a_oct_q == `PAT_ONES;
   assign pat_match[1] = sa5_oct_q == `PAT_ZERO && sa6_oct_q == `PAT_ALT &&
                         a_oct_q == `PAT_ONES;
   assign pat_match[2] = sa5_oct_q == `PAT_ZERO &&
                         sa6_oct_q == `PAT_ZERO;
   assign pat_en[0] = sel_q[`BIT_LB1];
   assign pat_en[1] = sel_q[`BIT_LB2];
   assign pat_en[2] = sel_q[`BIT_LBR];

   // One run counter per pattern; disabled counters stay at zero
   for (genvar p = 0; p < NPAT; p++) begin : g_pat
      pattern_run_counter #(
         .CNT_W(`CNT_W),
         .TARGET(`LOOP_COUNT)
      ) u_run (
         .clk(clk),
         .rstn(rstn),
         .clear(!pat_en[p] || !src_ok),
         .step(octet_done),
         .match(pat_match[p]),
         .cnt_q(pat_cnt[p]),
         .reached(pat_reached[p])
      );
   end

   // ----------------------------------------
   // Local loopback state
   // ----------------------------------------

   // Clearing both activation enables also drops the loop so software
   // is never stuck in loopback without a release pattern
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LOOP_OFF: begin
            if (pat_reached[0] || pat_reached[1]) begin
               state_d = LOOP_ON;
            end
         end
         LOOP_ON: begin
            if (pat_reached[2]) begin
               state_d = LOOP_OFF;
            end else if (!pat_en[0] && !pat_en[1]) begin
               state_d = LOOP_OFF;
            end
         end
         default: state_d = LOOP_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= LOOP_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   assign local_loop_en = (state_q == LOOP_ON);

   // ----------------------------------------
   // National bit insertion
   // ----------------------------------------

   // Sa4..Sa8 sit at ts0 bits 3..7, so the select bit index equals the position
   assign ins_slot = pos_p2_q.in_ts0 && pos_p2_q.nfas &&
                     pos_p2_q.ts0_bit >= `POS_SA4;
   assign sa_n = pos_p2_q.ts0_bit - `POS_SA4;

   // Register octets go out MSB first across the eight NFAS frames
   always_comb begin
      out_bit = ser_sync;
      if (ins_slot && sel_q[pos_p2_q.ts0_bit]) begin
         out_bit = sa_tx_q[sa_n][3'(`OCTET_LAST - pos_p2_q.nfas_index)];
      end
   end

   // Output bit is registered; strobe marks each new line bit
   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_bit_q <= 1'b0;
         out_strobe_q <= 1'b0;
      end else begin
         out_strobe_q <= strobe_p2_q;
         if (strobe_p2_q) begin
            out_bit_q <= out_bit;
         end
      end
   end

   assign tx_serial_out = out_bit_q;
   assign tx_out_strobe = out_strobe_q;

endmodule // e1_sa_select_loop

//--- design/e1_sa_consts.svh
// Register map, field positions and pattern constants of the national bit block
`ifndef E1_SA_CONSTS_SVH
`define E1_SA_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_DEFECT 10'h12b
`define IDX_SEL 10'h130
`define IDX_SA4 10'h133
`define IDX_SA8 10'h137
`define IDX_STATUS 10'h138
`define IDX_OCTETS 10'h139

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SEL_RST 8'h00
`define DEFECT_RST 8'h80
`define SA_REG_RST 8'hff

// ----------------------------------------
// Select register fields
// ----------------------------------------
`define BIT_LBR 0
`define BIT_LB2 1
`define BIT_LB1 2
`define BIT_SEL_SA5 4
`define BIT_SEL_SA6 5

// ----------------------------------------
// Positions inside time slot 0 of an NFAS frame
// ----------------------------------------
`define POS_A 3'h2
`define POS_SA4 3'h3
`define POS_SA5 3'h4
`define POS_SA6 3'h5
`define POS_SA8 3'h7
`define OCTET_LAST 3'h7

// ----------------------------------------
// Monitored patterns and run length
// ----------------------------------------
`define PAT_ZERO 8'h00
`define PAT_ONES 8'hff
`define PAT_ALT 8'haa
`define LOOP_COUNT 8
`define CNT_W 4

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/e1_sa_pkg.sv
// Types shared by the national bit select and auto loopback block
package e1_sa_pkg;

   // ----------------------------------------
   // AXI4-Lite request and response bundles
   // ----------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_s;

   // ----------------------------------------
   // Frame position from the transmit framer timing
   // ----------------------------------------
   typedef struct packed {
      logic in_ts0;
      logic nfas;
      logic [2:0] ts0_bit;
      logic [2:0] nfas_index;
   } frame_pos_s;

   // ----------------------------------------
   // Loopback state
   // ----------------------------------------
   typedef enum logic [1:0] {
      LOOP_OFF = 2'b01,
      LOOP_ON = 2'b10
   } loop_state_e;

endpackage

//--- design/bit_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Asynchronous level in, synchronous level out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // bit_sync2

//--- design/pattern_run_counter.sv
// Counts consecutive matching octets and flags a complete run
`timescale 1ns/1ps
`include "e1_sa_consts.svh"
module pattern_run_counter #(
   parameter int CNT_W = `CNT_W,
   parameter int TARGET = `LOOP_COUNT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Octet events
   input wire logic clear,
   input wire logic step,
   input wire logic match,
   // Run state
   output logic [CNT_W-1:0] cnt_q,
   output logic reached
);

   localparam logic [CNT_W-1:0] TGT = CNT_W'(TARGET);

   // Saturates at the target so a long run holds the flag
   always_ff @(posedge clk) begin
      if (!rstn || clear) begin
         cnt_q <= '0;
      end else if (step) begin
         if (!match) begin
            cnt_q <= '0;
         end else if (cnt_q != TGT) begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   assign reached = (cnt_q == TGT);

endmodule // pattern_run_counter

//--- sim/e1_sa_properties.sv
// Port checker for the national bit select and auto loopback block
`timescale 1ns/1ps
module e1_sa_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register bus
   input wire e1_sa_pkg::axi_req_s axi_req,
   input wire e1_sa_pkg::axi_rsp_s axi_rsp,
   // Serial path and loop state
   input wire logic bit_strobe,
   input wire e1_sa_pkg::frame_pos_s frame_pos,
   input wire logic tx_serial_input,
   input wire logic tx_serial_out,
   input wire logic tx_out_strobe,
   input wire logic local_loop_en
);
   import e1_sa_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [3:0] since_close_q;

   // ----
   // Helpers
   // ----
   // Cycles since an octet closed; saturates so a stale close never looks fresh
   always_ff @(posedge clk) begin
      if (!rstn) since_close_q <= 4'hf;
      else if (bit_strobe && frame_pos == frame_pos_s'{1'b1, 1'b1, 3'h7, 3'h7}) since_close_q <= 4'h0;
      else if (since_close_q != 4'hf) since_close_q <= since_close_q + 4'h1;
   end
   sequence s_write_taken;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && !axi_rsp.bvalid;
   endsequence
   sequence s_line_bit;
      bit_strobe && !(frame_pos.in_ts0 && frame_pos.nfas && frame_pos.ts0_bit >= 3'h3);
   endsequence

   // ----
   // Properties
   // ----
   chk_strobe_delay: assert property (bit_strobe |-> ##3 tx_out_strobe)
      else $error("output strobe missing three cycles after a bit strobe");
   chk_strobe_cause: assert property (tx_out_strobe |-> $past(bit_strobe, 3))
      else $error("output strobe without a bit strobe");
   chk_line_steady: assert property ($changed(tx_serial_out) |-> tx_out_strobe)
      else $error("line bit changed without a strobe");
   chk_pin_passes: assert property (s_line_bit |-> ##3 (tx_serial_out == $past(tx_serial_input, 3)))
      else $error("line bit differs from pin bit");
   chk_write_answer: assert property (s_write_taken |-> ##2 axi_rsp.bvalid)
      else $error("write response late");
   chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read data late");
   chk_write_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response held after acceptance");
   chk_read_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read data held after acceptance");
   chk_loop_at_close: assert property ($rose(local_loop_en) |-> since_close_q == 4'h3)
      else $error("loopback entered away from an octet close");
endmodule // e1_sa_properties

bind e1_sa_select_loop e1_sa_properties i_chk (.clk(clk), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .bit_strobe(bit_strobe), .frame_pos(frame_pos), .tx_serial_input(tx_serial_input),
   .tx_serial_out(tx_serial_out), .tx_out_strobe(tx_out_strobe), .local_loop_en(local_loop_en));

//--- sim/backplane_source.sv
// Backplane source: streams time slot 0 bits with the monitored octets
`timescale 1ns/1ps
module backplane_source (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Stream control
   input wire logic run,
   input wire logic slow,
   input wire logic [7:0] sa5_oct,
   input wire logic [7:0] sa6_oct,
   input wire logic [7:0] a_oct,
   output logic idle,
   // Backplane stream
   output logic bit_strobe = 1'b0,
   output e1_sa_pkg::frame_pos_s frame_pos = '0,
   output logic tx_serial_input = 1'b0
);
   import e1_sa_pkg::*;
   localparam logic [7:0] ALIGN = 8'h1b;
   logic [3:0] frame_q = 4'h0;
   logic [3:0] bit_q = 4'h0;
   logic [2:0] gap_q = 3'h0;

   // A multiframe is never cut short, so octets always arrive whole
   assign idle = frame_q == 4'h0 && bit_q == 4'h0 && gap_q == 3'h0;

   // Pin bit: alignment word in even frames, monitored octets MSB first in odd ones
   function automatic logic bit_val(logic [3:0] f, logic [3:0] b);
      logic [2:0] i;
      i = 3'h7 - f[3:1];
      if (b > 4'h7) return 1'($urandom);
      if (!f[0]) return ALIGN[3'h7 - b[2:0]];
      case (b)
         4'h1: return 1'b1;
         4'h2: return a_oct[i];
         4'h4: return sa5_oct[i];
         4'h5: return sa6_oct[i];
         default: return 1'($urandom);
      endcase
   endfunction

   always_ff @(posedge clk) begin
      bit_strobe <= rstn && gap_q == 3'h0 && (run || !idle);
   end

   // Pin holds at least two cycles past each strobe; toggles while released
   always_ff @(posedge clk) begin
      if (!rstn) begin
         frame_q <= 4'h0;
         bit_q <= 4'h0;
         gap_q <= 3'h0;
      end else if (gap_q != 3'h0) begin
         gap_q <= gap_q - 3'h1;
      end else if (run || !idle) begin
         gap_q <= slow ? 3'(3 + $urandom % 4) : 3'h2;
         frame_pos <= '{bit_q < 4'h8, frame_q[0], bit_q[2:0], frame_q[3:1]};
         tx_serial_input <= bit_val(frame_q, bit_q);
         bit_q <= bit_q == 4'h8 ? 4'h0 : bit_q + 4'h1;
         if (bit_q == 4'h8) frame_q <= frame_q + 4'h1;
      end else begin
         tx_serial_input <= ~tx_serial_input;
      end
   end
endmodule // backplane_source

//--- sim/e1_sa_select_loop_test.sv
// Self-checking bench for the national bit select and auto loopback block
`timescale 1ns/1ps
module e1_sa_select_loop_test;
   import e1_sa_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   axi_req_s req = '0;
   axi_rsp_s rsp;
   frame_pos_s frame_pos;
   logic bit_strobe, tx_serial_input, tx_serial_out, tx_out_strobe, local_loop_en, defect_detect_on, idle;
   logic run = 1'b0;
   logic slow = 1'b0;
   logic [7:0] sa5_o = 8'h0, sa6_o = 8'h0, a_o = 8'h0, v;
   logic [7:0] sel_m = 8'h0;
   logic [7:0] sa_m [3:7] = '{default: 8'hff};
   logic q[$];
   int n_mismatch = 0, num_checks = 0, n_start = 0;
   logic [31:0] rd;
   logic [1:0] rr;

   always #2.5 clk = ~clk;

   e1_sa_select_loop i_dut (.clk(clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .bit_strobe(bit_strobe),
      .frame_pos(frame_pos), .tx_serial_input(tx_serial_input), .tx_serial_out(tx_serial_out),
      .tx_out_strobe(tx_out_strobe), .local_loop_en(local_loop_en), .defect_detect_on(defect_detect_on));
   backplane_source i_src (.clk(clk), .rstn(rstn), .run(run), .slow(slow), .sa5_oct(sa5_o), .sa6_oct(sa6_o),
      .a_oct(a_o), .idle(idle), .bit_strobe(bit_strobe), .frame_pos(frame_pos), .tx_serial_input(tx_serial_input));

   // ----
   // Checking
   // ----
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   function automatic logic exp_bit(frame_pos_s p, logic pin);
      if (p.in_ts0 && p.nfas && p.ts0_bit >= 3'h3 && sel_m[p.ts0_bit]) return sa_m[p.ts0_bit][3'h7 - p.nfas_index];
      return pin;
   endfunction

   // Expected line bit queued per strobe, compared when the delayed strobe emerges
   always @(posedge clk) begin
      if (bit_strobe) q.push_back(exp_bit(frame_pos, tx_serial_input));
      if (bit_strobe && frame_pos == frame_pos_s'{1'b1, 1'b0, 3'h0, 3'h0}) n_start <= n_start + 1;
      if (tx_out_strobe) cmp_bit(tx_serial_out, q.pop_front());
   end

   // ----
   // Bus and stream tasks
   // ----
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      rr = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a);
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   // Writes and reads back; only called while the stream is stopped
   task automatic wr_chk(input logic [11:0] a, input logic [7:0] d);
      wr(a, {24'h0, d});
      cmp_word({30'h0, rr}, 32'h0);
      rdr(a);
      cmp_word(rd, {24'h0, d});
   endtask
   // Streams n whole multiframes, then waits for the pipeline and loop logic to settle
   task automatic run_mf(input logic [7:0] s5, input logic [7:0] s6, input logic [7:0] a, input int n);
      int s;
      s = n_start;
      sa5_o <= s5;
      sa6_o <= s6;
      a_o <= a;
      run <= 1'b1;
      while (n_start < s + n) @(posedge clk);
      run <= 1'b0;
      do @(posedge clk); while (!idle || q.size() != 0);
      repeat (8) @(posedge clk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ----
   // Tests
   // ----
   initial begin
      void'($urandom(32'hf112));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rdr(12'h4c0);
      cmp_word(rd, 32'h0);
      for (int k = 3; k < 8; k++) begin
         rdr(12'h4c0 + 12'(4 * k));
         cmp_word(rd, 32'hff);
      end
      rdr(12'h4ac);
      cmp_word(rd, 32'h80);
      cmp_bit(local_loop_en, 1'b0);
      wr_chk(12'h4ac, 8'h80);
      cmp_bit(defect_detect_on, 1'b1);
      rdr(12'h4b0);
      cmp_word({rd[29:0], rr}, 32'h2);
      wr(12'h4b0, 32'h1);
      cmp_word({30'h0, rr}, 32'h2);
      $display("test registers done");
      wr_chk(12'h4c0, 8'h04);
      run_mf(8'h00, 8'hff, 8'hff, 7);
      cmp_bit(local_loop_en, 1'b0);
      run_mf(8'h00, 8'hff, 8'hff, 1);
      cmp_bit(local_loop_en, 1'b1);
      rdr(12'h4e0);
      cmp_word(rd, 32'h81);
      rdr(12'h4e4);
      cmp_word(rd, 32'hffff00);
      $display("test pattern_one done");
      wr_chk(12'h4c0, 8'h05);
      run_mf(8'h00, 8'h00, 8'h5a, 4);
      run_mf(8'h00, 8'h02, 8'h5a, 1);
      run_mf(8'h00, 8'h00, 8'h5a, 7);
      cmp_bit(local_loop_en, 1'b1);
      run_mf(8'h00, 8'h00, 8'h5a, 1);
      cmp_bit(local_loop_en, 1'b0);
      $display("test release done");
      wr_chk(12'h4c0, 8'h34);
      sel_m = 8'h30;
      run_mf(8'h00, 8'hff, 8'hff, 8);
      cmp_bit(local_loop_en, 1'b0);
      $display("test register_sourced done");
      wr_chk(12'h4c0, 8'h02);
      sel_m = 8'h00;
      run_mf(8'h00, 8'haa, 8'hfe, 8);
      cmp_bit(local_loop_en, 1'b0);
      slow <= 1'b1;
      run_mf(8'h00, 8'haa, 8'hff, 8);
      cmp_bit(local_loop_en, 1'b1);
      slow <= 1'b0;
      $display("test pattern_two done");
      // Corners first: every national bit from registers, then none
      for (int t = 0; t < 4; t++) begin
         v = t == 0 ? 8'hf8 : t == 1 ? 8'h00 : 8'($urandom) & 8'hf8;
         for (int k = 3; k < 8; k++) begin
            sa_m[k] = 8'($urandom);
            wr_chk(12'h4c0 + 12'(4 * k), sa_m[k]);
         end
         wr_chk(12'h4c0, v);
         sel_m = v;
         run_mf(8'($urandom), 8'($urandom), 8'($urandom), 2);
      end
      $display("test select done");
      complete_run();
   end

   // Hang guard, well above the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
endmodule // e1_sa_select_loop_test
